/* File: logic/audio_amp_system_control_regs.sv */
// audio_amp_system_control_regs: system-control register bank of the audio amplifier
// and the small control logic it steers (clock-error unmute ramp, mid-level ramp, fault pin).
// assumes: the serial control interface has already decoded subaddress and byte;
// sample tick, clock error and fault detect come from logic on clk.
//
// Contract
// - dc-block bit cleared bypasses the dc-blocking filter on every channel
// - dc-block bit set (reset) enables the dc-blocking high-pass filter per channel
// - unmute bit cleared: soft unmute after clock error, lasting the volume ramp time
// - unmute bit set (reset): full volume in one step after clock error
// - bits 1:0 choose de-emphasis: none, 32 kHz, 44.1 kHz, 48 kHz
// - serial format resets to 24-bit I2S
// - format code bits 3:0, upper bits zero; codes 9-15 reserved, never written
// - shutdown bit low plays audio; high (reset) shuts all outputs down
// - fault-pin bit clear makes the pin an input; set drives it as fault output
// - quiet bits 0..2 force channels 1..3 to half duty cycle; zero unmutes
// - soft unmute ramp follows volume slew steps, paced by the sample rate

`timescale 1ns/1ps
`default_nettype none

module audio_amp_system_control_regs
	import amp_sysctl_pkg::*;
(
	input  wire logic                clk,
	input  wire logic                sys_rst,
	input  wire logic                regWrite,
	input  wire logic                regRead,
	input  wire logic [7:0]          regAddr,
	input  wire logic [7:0]          regWdata,
	output logic      [7:0]          regRdata,
	input  wire logic                sampleTick,
	input  wire logic                clockError,
	input  wire logic [2:0]          volSlew,
	input  wire logic                faultDetect,
	input  wire logic                faultPinIn,
	output logic                     faultPinOut,
	output logic                     faultPinOe,
	output logic                     addrSelect,
	output logic                     dcBlockEn,
	output amp_sysctl_pkg::deemph_e  deemphSel,
	output logic      [3:0]          formatCode,
	output logic                     shutdown,
	output logic      [2:0]          channelQuiet,
	output logic      [12:0]         recoveryGain,
	output logic                     midRampActive
);
	import amp_sysctl_pkg::*;

	// ********************************
	// helpers
	// ********************************
	// gain increment per sample step so that full gain takes the slew's step count
	function automatic logic [12:0] slewInc(input logic [2:0] code);
		logic [12:0] inc;
		inc = 13'h0008;
		unique case (code)
			SLEW_1024: inc = 13'h0004;
			SLEW_2048: inc = 13'h0002;
			SLEW_256:  inc = 13'h0010;
			default:   inc = 13'h0008;
		endcase
		return inc;
	endfunction

	function automatic logic [12:0] stepUp(input logic [12:0] g, input logic [12:0] inc);
		logic [13:0] sum;
		sum = {1'b0, g} + {1'b0, inc};
		return (sum >= {1'b0, GAIN_FULL}) ? GAIN_FULL : sum[12:0];
	endfunction

	// ********************************
	// register file
	// ********************************
	logic [7:0] sysOne_r, sysOne_nxt;
	logic [7:0] format_r, format_nxt;
	logic [7:0] sysTwo_r, sysTwo_nxt;
	logic [7:0] quiet_r, quiet_nxt;
	logic [7:0] rdata_r, rdata_nxt;

	always_comb begin
		sysOne_nxt = sysOne_r;
		format_nxt = format_r;
		sysTwo_nxt = sysTwo_r;
		quiet_nxt  = quiet_r;
		rdata_nxt  = rdata_r;
		if (regWrite) begin
			unique case (regAddr)
				// only defined bits are stored; reserved bits read as zero
				SYSTEM_CONTROL_ONE_OFS: sysOne_nxt = regWdata & 8'hA3;
				SERIAL_FORMAT_SELECT_OFS: begin
					// a reserved code is dropped so the input format never goes undefined
					if (regWdata[3:0] <= FORMAT_LAST) begin
						format_nxt = {4'h0, regWdata[3:0]};
					end
				end
				SYSTEM_CONTROL_TWO_OFS: sysTwo_nxt = regWdata & 8'hC2;
				CHANNEL_QUIET_CONTROL_OFS: quiet_nxt = regWdata & 8'h07;
				default: ;
			endcase
		end
		if (regRead) begin
			unique case (regAddr)
				SYSTEM_CONTROL_ONE_OFS:    rdata_nxt = sysOne_r;
				SERIAL_FORMAT_SELECT_OFS:  rdata_nxt = format_r;
				SYSTEM_CONTROL_TWO_OFS:    rdata_nxt = sysTwo_r;
				CHANNEL_QUIET_CONTROL_OFS: rdata_nxt = quiet_r;
				default:                   rdata_nxt = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sysOne_r <= SYSTEM_CONTROL_ONE_RST;
			format_r <= SERIAL_FORMAT_SELECT_RST;
			sysTwo_r <= SYSTEM_CONTROL_TWO_RST;
			quiet_r  <= CHANNEL_QUIET_CONTROL_RST;
			rdata_r  <= 8'h00;
		end else begin
			sysOne_r <= sysOne_nxt;
			format_r <= format_nxt;
			sysTwo_r <= sysTwo_nxt;
			quiet_r  <= quiet_nxt;
			rdata_r  <= rdata_nxt;
		end
	end

	assign regRdata     = rdata_r;
	assign dcBlockEn    = sysOne_r[DC_BLOCK_BIT];
	assign deemphSel    = deemph_e'(sysOne_r[DEEMPH_LSB +: 2]);
	assign formatCode   = format_r[FORMAT_LSB +: 4];
	assign shutdown     = sysTwo_r[SHUTDOWN_BIT];
	assign channelQuiet = quiet_r[QUIET_LSB +: 3];

	// ********************************
	// clock-error recovery and mid-level ramp
	// ********************************
	logic [12:0] gain_r, gain_nxt;
	logic [12:0] mid_r, mid_nxt;
	logic        errSeen_r, errSeen_nxt;
	logic        shutPrev_r, shutPrev_nxt;
	logic        midAct_r, midAct_nxt;

	always_comb begin
		gain_nxt     = gain_r;
		mid_nxt      = mid_r;
		errSeen_nxt  = clockError;
		shutPrev_nxt = sysTwo_r[SHUTDOWN_BIT];
		midAct_nxt   = midAct_r;
		if (clockError) begin
			gain_nxt = GAIN_ZERO;
		end else if (errSeen_r && sysOne_r[HARD_UNMUTE_BIT]) begin
			gain_nxt = GAIN_FULL;
		end else if (sampleTick) begin
			// soft ramp: one step per sample, stays at full once reached
			gain_nxt = stepUp(gain_r, slewInc(volSlew));
		end
		if (sysTwo_r[SHUTDOWN_BIT] != shutPrev_r && sysTwo_r[MID_RAMP_BIT]) begin
			midAct_nxt = 1'b1;
			mid_nxt    = GAIN_ZERO;
		end else if (midAct_r && sampleTick) begin
			mid_nxt = stepUp(mid_r, slewInc(volSlew));
			if (mid_nxt == GAIN_FULL) begin
				midAct_nxt = 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			gain_r     <= GAIN_FULL;
			mid_r      <= GAIN_ZERO;
			errSeen_r  <= 1'b0;
			shutPrev_r <= 1'b1;
			midAct_r   <= 1'b0;
		end else begin
			gain_r     <= gain_nxt;
			mid_r      <= mid_nxt;
			errSeen_r  <= errSeen_nxt;
			shutPrev_r <= shutPrev_nxt;
			midAct_r   <= midAct_nxt;
		end
	end

	assign recoveryGain  = gain_r;
	assign midRampActive = midAct_r;

	// ********************************
	// address-select / fault pin
	// ********************************
	logic selMeta_r, selSync_r, selSync_nxt;
	logic pinOut_r, pinOut_nxt;
	logic pinOe_r, pinOe_nxt;

	always_comb begin
		selSync_nxt = selMeta_r;
		pinOe_nxt   = sysTwo_r[FAULT_OUT_BIT];
		// fault output is active low, released high while no fault
		pinOut_nxt  = ~faultDetect;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			selMeta_r <= 1'b0;
			selSync_r <= 1'b0;
			pinOut_r  <= 1'b1;
			pinOe_r   <= 1'b0;
		end else begin
			selMeta_r <= faultPinIn;
			selSync_r <= selSync_nxt;
			pinOut_r  <= pinOut_nxt;
			pinOe_r   <= pinOe_nxt;
		end
	end

	assign addrSelect  = selSync_r;
	assign faultPinOut = pinOut_r;
	assign faultPinOe  = pinOe_r;

endmodule

`default_nettype wire

/* File: logic/amp_sysctl_pkg.sv */
// amp_sysctl_pkg: offsets, reset values, field positions and codes for the amplifier
// system-control register bank.
// assumes: 8-bit registers, one per subaddress, on the serial control interface.

package amp_sysctl_pkg;

	// ********************************
	// register subaddresses
	// ********************************
	localparam logic [7:0] SYSTEM_CONTROL_ONE_OFS    = 8'h03;
	localparam logic [7:0] SERIAL_FORMAT_SELECT_OFS  = 8'h04;
	localparam logic [7:0] SYSTEM_CONTROL_TWO_OFS    = 8'h05;
	localparam logic [7:0] CHANNEL_QUIET_CONTROL_OFS = 8'h06;

	// ********************************
	// values after reset
	// ********************************
	localparam logic [7:0] SYSTEM_CONTROL_ONE_RST    = 8'hA0;
	localparam logic [7:0] SERIAL_FORMAT_SELECT_RST  = 8'h05;
	localparam logic [7:0] SYSTEM_CONTROL_TWO_RST    = 8'h40;
	localparam logic [7:0] CHANNEL_QUIET_CONTROL_RST = 8'h00;

	// ********************************
	// field positions
	// ********************************
	localparam int DC_BLOCK_BIT    = 7;
	localparam int HARD_UNMUTE_BIT = 5;
	localparam int DEEMPH_LSB      = 0;
	localparam int FORMAT_LSB      = 0;
	localparam int MID_RAMP_BIT    = 7;
	localparam int SHUTDOWN_BIT    = 6;
	localparam int FAULT_OUT_BIT   = 1;
	localparam int QUIET_LSB       = 0;

	// highest legal serial format code; codes above are reserved
	localparam logic [3:0] FORMAT_LAST = 4'h8;

	// de-emphasis codes
	typedef enum logic [1:0] {
		DEEMPH_NONE = 2'h0,
		DEEMPH_32K  = 2'h1,
		DEEMPH_44K1 = 2'h2,
		DEEMPH_48K  = 2'h3
	} deemph_e;

	// ramp gain scale: full gain is reached after the selected number of steps
	localparam int         GAIN_W    = 13;
	localparam logic [12:0] GAIN_FULL = 13'h1000;
	localparam logic [12:0] GAIN_ZERO = 13'h0000;

	// volume slew codes: 512, 1024, 2048, 256 steps
	localparam logic [2:0] SLEW_512  = 3'h0;
	localparam logic [2:0] SLEW_1024 = 3'h1;
	localparam logic [2:0] SLEW_2048 = 3'h2;
	localparam logic [2:0] SLEW_256  = 3'h3;

endpackage

/* File: test/sysctl_chk.sv */
// sysctl_chk: port assertions for the system-control register bank
// assumes: bound to the bank, one clock, writes spaced by an idle cycle
`timescale 1ns/1ps
`default_nettype none
module sysctl_chk
	import amp_sysctl_pkg::*;
(
	input wire logic        clk,
	input wire logic        sys_rst,
	input wire logic        regWrite,
	input wire logic [7:0]  regAddr,
	input wire logic [7:0]  regWdata,
	input wire logic        clockError,
	input wire logic        faultPinOe,
	input wire logic        dcBlockEn,
	input wire logic [3:0]  formatCode,
	input wire logic        shutdown,
	input wire logic [2:0]  channelQuiet,
	input wire logic [12:0] recoveryGain,
	input wire logic [1:0]  deemphSel,
	input wire logic        midRampActive,
	input wire logic        faultDetect,
	input wire logic        faultPinOut
);
	// ****
	// properties
	// ****
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	logic hardR;
	// mirror of the unmute-mode bit, which has no port of its own
	always_ff @(posedge clk)
		hardR <= sys_rst ? 1'b1 : (regWrite && regAddr == 8'h03) ? regWdata[5] : hardR;
	sequence wrAt(a);
		regWrite && regAddr == a;
	endsequence
	AST_DCBLK: assert property (wrAt(8'h03) |=> dcBlockEn == $past(regWdata[7]))
		else $error("dc block bit");
	AST_FMT_OK: assert property (wrAt(8'h04) ##0 regWdata[3:0] <= 4'h8
		|=> formatCode == $past(regWdata[3:0])) else $error("format not taken");
	AST_FMT_NO: assert property (wrAt(8'h04) ##0 regWdata[3:0] > 4'h8 |=> $stable(formatCode))
		else $error("reserved format taken");
	AST_SHDN: assert property (wrAt(8'h05) |=> shutdown == $past(regWdata[6]))
		else $error("shutdown bit");
	AST_QUIET: assert property (wrAt(8'h06) |=> channelQuiet == $past(regWdata[2:0]))
		else $error("quiet bits");
	AST_OE: assert property (wrAt(8'h05) |=> ##1 faultPinOe == $past(regWdata[1], 2))
		else $error("pin direction");
	AST_MUTE: assert property (clockError |=> recoveryGain == 13'h0000)
		else $error("gain not muted");
	AST_HARD: assert property ($fell(clockError) && hardR |-> ##[1:2] recoveryGain == 13'h1000)
		else $error("hard unmute late");
	AST_SOFT: assert property ($fell(clockError) && !hardR |=> recoveryGain != 13'h1000)
		else $error("soft unmute jumped");
	AST_DEEMPH: assert property (wrAt(8'h03) |=> deemphSel == $past(regWdata[1:0]))
		else $error("de-emphasis code");
	AST_RST_VAL: assert property ($fell(sys_rst) |-> formatCode == 4'h5 && shutdown && dcBlockEn)
		else $error("reset values");
	AST_MID_ON: assert property ($rose(midRampActive) |-> $past(shutdown) != $past(shutdown, 2))
		else $error("mid ramp without shutdown change");
	// the first edge after reset still shows the reset level of the pin
	AST_FAULT_OUT: assert property (!$past(sys_rst) |-> faultPinOut == !$past(faultDetect))
		else $error("fault pin level");
endmodule
bind audio_amp_system_control_regs sysctl_chk chk (.clk, .sys_rst, .regWrite, .regAddr,
	.regWdata, .clockError, .faultPinOe, .dcBlockEn, .formatCode, .shutdown, .channelQuiet,
	.recoveryGain, .deemphSel, .midRampActive, .faultDetect, .faultPinOut);
`default_nettype wire

/* File: test/host_model.sv */
// host_model: control host issuing single-byte register accesses
// assumes: inputs change on the falling edge of clk
`timescale 1ns/1ps
`default_nettype none
module host_model (
	input  wire logic       clk,
	output logic            regWrite,
	output logic            regRead,
	output logic [7:0]      regAddr,
	output logic [7:0]      regWdata
);
	initial begin
		regWrite = 1'b0;
		regRead = 1'b0;
		regAddr = 8'h00;
		regWdata = 8'h00;
	end
	// strobe stands for one rising edge; released bus shows the inverse
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		regWrite = w;
		regRead = !w;
		regAddr = a;
		regWdata = d;
		@(negedge clk);
		regWrite = 1'b0;
		regRead = 1'b0;
		regAddr = ~a;
		regWdata = ~d;
	endtask
endmodule
`default_nettype wire

/* File: test/tb_audio_amp_system_control_regs.sv */
// tb_audio_amp_system_control_regs: self-checking bench for the register bank
// assumes: host_model and the bound checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_audio_amp_system_control_regs;
	import amp_sysctl_pkg::*;
	logic        clk, sys_rst, regWrite, regRead, sampleTick, clockError, rdPend, prev;
	logic        faultDetect, faultPinIn, faultPinOut, faultPinOe, addrSelect;
	logic        dcBlockEn, shutdown, midRampActive;
	logic [7:0]  regAddr, regWdata, regRdata, w;
	logic [2:0]  volSlew, channelQuiet;
	logic [3:0]  formatCode, lastFmt;
	logic [12:0] recoveryGain;
	deemph_e     deemphSel;
	logic [7:0]  expQ[$];
	int          n_errors, checks, nSteps;
	audio_amp_system_control_regs uut (.*);
	host_model host (.*);
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic cmp(input logic [12:0] got, input logic [12:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic final_report;
		$display("errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		expQ.push_back(e);
		host.xfer(1'b0, a, 8'h00);
	endtask
	task automatic ticks(input int n);
		repeat (n) begin
			@(negedge clk);
			sampleTick = 1'b1;
			@(negedge clk);
			sampleTick = 1'b0;
		end
	endtask
	// read data is settled by the falling edge after the sampling edge
	always @(posedge clk) rdPend <= regRead && !sys_rst;
	always @(negedge clk) begin
		if (rdPend) cmp(13'(regRdata), 13'(expQ.pop_front()));
	end
	initial begin
		#500000;
		n_errors++;
		final_report;
	end
	initial begin
		void'($urandom(32'h40b9));
		{sys_rst, sampleTick, clockError, faultDetect, faultPinIn, volSlew} = 8'h80;
		lastFmt = 4'h5;
		prev = 1'b1;
		repeat (16) @(negedge clk);
		sys_rst = 1'b0;
		rd(8'h03, 8'hA0);
		rd(8'h04, 8'h05);
		rd(8'h05, 8'h40);
		rd(8'h06, 8'h00);
		rd(8'h07, 8'h00);
		for (int i = 0; i < 8; i++) begin
			w = (8'($urandom) & 8'hFC) | 8'(i % 4);
			host.xfer(1'b1, 8'h03, w);
			cmp(13'(deemphSel), 13'(w[1:0]));
			cmp(13'(dcBlockEn), 13'(w[7]));
			rd(8'h03, w & 8'hA3);
		end
		for (int i = 0; i < 16; i++) begin
			host.xfer(1'b1, 8'h04, {4'($urandom), 4'(i)});
			if (i < 9) lastFmt = 4'(i);
			rd(8'h04, {4'h0, lastFmt});
		end
		for (int i = 0; i < 4; i++) begin
			w = 8'($urandom);
			w[7] = ~i[0];
			w[6] = i[1];
			{faultDetect, faultPinIn} = 2'($urandom);
			host.xfer(1'b1, 8'h05, w);
			cmp(13'(shutdown), 13'(w[6]));
			@(negedge clk);
			cmp(13'(midRampActive), 13'(w[7] && w[6] != prev));
			ticks(511);
			// one step short of the slew count the ramp must still be running
			cmp(13'(midRampActive), 13'(w[7] && w[6] != prev));
			prev = w[6];
			ticks(1);
			cmp(13'(midRampActive), 13'h0000);
			cmp(13'(faultPinOe), 13'(w[1]));
			cmp(13'(faultPinOut), 13'(!faultDetect));
			cmp(13'(addrSelect), 13'(faultPinIn));
			rd(8'h05, w & 8'hC2);
			host.xfer(1'b1, 8'h06, w);
			cmp(13'(channelQuiet), 13'(w[2:0]));
			rd(8'h06, w & 8'h07);
		end
		host.xfer(1'b1, 8'h03, 8'hA0);
		clockError = 1'b1;
		repeat (3) @(negedge clk);
		cmp(recoveryGain, 13'h0000);
		clockError = 1'b0;
		repeat (3) @(negedge clk);
		cmp(recoveryGain, 13'h1000);
		host.xfer(1'b1, 8'h03, 8'h80);
		// slew codes 0 to 3: 512, 1024, 2048 and 256 steps to full gain
		for (int s = 0; s < 4; s++) begin
			volSlew = 3'(s);
			nSteps = (s == 0) ? 512 : (s == 1) ? 1024 : (s == 2) ? 2048 : 256;
			clockError = 1'b1;
			repeat (3) @(negedge clk);
			clockError = 1'b0;
			repeat (2) @(negedge clk);
			ticks(nSteps - 1);
			@(negedge clk);
			cmp(recoveryGain, 13'(4096 - 4096 / nSteps));
			ticks(1);
			@(negedge clk);
			cmp(recoveryGain, 13'h1000);
		end
		// reset in mid-run must bring system control one, serial format and system control two back to their reset values
		sys_rst = 1'b1;
		repeat (2) @(negedge clk);
		sys_rst = 1'b0;
		cmp(13'(faultPinOe), 13'h0000);
		rd(8'h03, 8'hA0);
		rd(8'h04, 8'h05);
		rd(8'h05, 8'h40);
		final_report;
	end
endmodule
`default_nettype wire
